/* File: src/sadc_control.sv */
// Purpose: Conversion, mode and readout control of an eight-channel
//          simultaneous-sampling converter.
// Assumes: All pins except adcCode are asynchronous to ref_clk.
// Notes:   Results pass a small FIFO; it drains only outside frames.
`timescale 1ns/1ns
module sadc_control
   import sadc_pkg::*;
   (input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              triggerA,
    input  wire logic              triggerB,
    input  wire logic              referenceSelect,
    input  wire logic              rangeSelect,
    input  wire logic              powerDownN,
    input  wire logic              interfaceSelect,
    input  wire logic              byteSerialSelect,
    input  wire logic              highByteFirst,
    input  wire logic              readStrobeClk,
    input  wire logic              chipSelectN,
    input  wire logic [CODE_W-1:0] adcCode,
    output logic      [CH_W-1:0]   adcChannel,
    output logic                   holdA,
    output logic                   holdB,
    output logic                   busy,
    output logic                   resultValid,
    output logic                   firstData,
    output logic      [BUS_W-1:0]  dataOut,
    output logic                   dataOe,
    output logic                   serialOutA,
    output logic                   serialOutB,
    output logic                   serialOe,
    output logic                   referencePinOe,
    output logic                   bandgapOn,
    output logic                   referenceBufferOn,
    output logic                   rangeWide,
    output logic      [STEP_W-1:0] codeStepNv,
    output logic                   shutdown,
    output logic                   standby);

   typedef struct packed {
      logic [NSYNC-1:0]                s1;
      logic [NSYNC-1:0]                s2;
      logic [NSYNC-1:0]                s3;
      logic [NSYNC-1:0]                lvl;
      logic                            armA;
      logic                            armB;
      logic                            holdA;
      logic                            holdB;
      logic                            busy;
      logic                            valid;
      sadc_conv_t                      conv;
      logic [CH_W-1:0]                 convCh;
      logic [CNT_W-1:0]                convCnt;
      logic [CODE_W-1:0]               convCode;
      logic [CH_W:0]                   latched;
      logic [NUM_CH-1:0][CODE_W-1:0]   result;
      logic                            inFrame;
      logic [RD_W-1:0]                 rdIdx;
      logic [BUS_W-1:0]                dataOut;
      logic                            firstData;
      logic [HALF_CH*CODE_W-1:0]       shA;
      logic [HALF_CH*CODE_W-1:0]       shB;
      logic [BIT_W-1:0]                bitCnt;
   } sadc_state_t;

   sadc_state_t      s;
   sadc_state_t      next_s;
   logic [NSYNC-1:0] agree;
   logic [NSYNC-1:0] nl;
   logic [NSYNC-1:0] rise;
   logic [NSYNC-1:0] fall;
   sadc_mode_t       mode;
   logic [CH_W-1:0]  chIdx;
   logic [BUS_W-1:0] word;
   logic             fifoInReady;
   logic             fifoOutValid;
   logic             fifoOutReady;
   logic [WORD_W-1:0] fifoOutData;

   // ------------------------------------------------------------
   // Static pins act straight through, no clock involved
   // ------------------------------------------------------------
   assign referencePinOe    = referenceSelect;
   assign bandgapOn         = referenceSelect;
   assign referenceBufferOn = 1'b1;
   assign rangeWide         = rangeSelect;
   assign codeStepNv = rangeSelect ? STEP_WIDE_NV
                                   : STEP_NARROW_NV;
   // Span select doubles as the power-down flavour
   assign shutdown = !powerDownN && !rangeSelect;
   assign standby  = !powerDownN && rangeSelect;

   // ------------------------------------------------------------
   // Result FIFO; drained only while no frame is open
   // ------------------------------------------------------------
   assign fifoOutReady = s.lvl[IN_CSN];

   sadc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .inValid  (s.conv == CONV_PUSH),
      .inReady  (fifoInReady),
      .inData   ({s.convCh, s.convCode}),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData));

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign adcChannel  = s.convCh;
   assign holdA       = s.holdA;
   assign holdB       = s.holdB;
   assign busy        = s.busy;
   assign resultValid = s.valid;
   assign firstData   = s.firstData;
   assign dataOut     = s.dataOut;
   assign serialOutA  = s.shA[HALF_CH*CODE_W-1];
   assign serialOutB  = s.shB[HALF_CH*CODE_W-1];
   assign dataOe   = s.inFrame && mode != MODE_SER
                     && !s.lvl[IN_RDCLK];
   assign serialOe = s.inFrame && mode == MODE_SER;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      // A pin change counts once the second and third stages agree
      next_s.s1 = {highByteFirst, byteSerialSelect, interfaceSelect,
                   powerDownN, chipSelectN, readStrobeClk,
                   triggerB, triggerA};
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      agree = ~(s.s2 ^ s.s3);
      nl    = (agree & s.s3) | (~agree & s.lvl);
      rise  = nl & ~s.lvl;
      fall  = ~nl & s.lvl;
      next_s.lvl = nl;
      mode  = sadc_mode(s.lvl[IN_IFSEL], s.lvl[IN_BSEL]);
      chIdx = '0;
      word  = '0;

      // Triggers; both halves must rise before the run starts, and
      // edges during a run or in power-down are ignored
      if (!s.busy && s.lvl[IN_PDN]) begin
         if (rise[IN_TRGA]) begin
            next_s.armA  = 1'b1;
            next_s.holdA = 1'b1;
         end
         if (rise[IN_TRGB]) begin
            next_s.armB  = 1'b1;
            next_s.holdB = 1'b1;
         end
         // Tied triggers arrive in the same cycle here
         if (next_s.armA && next_s.armB) begin
            next_s.busy    = 1'b1;
            next_s.valid   = 1'b0;
            next_s.conv    = CONV_RUN;
            next_s.convCh  = '0;
            next_s.convCnt = '0;
            next_s.latched = '0;
         end
      end

      // Conversion sequencer, paced by ref_clk as internal clock
      unique case (s.conv)
         CONV_IDLE: begin
         end
         CONV_RUN: begin
            next_s.convCnt = s.convCnt + 1'b1;
            if (s.convCnt == CNT_W'(CONV_CYCLES - 1)) begin
               next_s.convCode = adcCode;
               next_s.conv     = CONV_PUSH;
            end
         end
         CONV_PUSH: begin
            // A full FIFO stalls the sequencer here
            if (fifoInReady) begin
               next_s.convCnt = '0;
               if (s.convCh == CH_W'(NUM_CH - 1)) begin
                  next_s.conv = CONV_WAIT;
               end else begin
                  next_s.convCh = s.convCh + 1'b1;
                  next_s.conv   = CONV_RUN;
               end
            end
         end
         CONV_WAIT: begin
            if (s.latched == LATCH_ALL) begin
               next_s.busy  = 1'b0;
               next_s.valid = 1'b1;
               next_s.armA  = 1'b0;
               next_s.armB  = 1'b0;
               // Front ends go back to tracking at once
               next_s.holdA = 1'b0;
               next_s.holdB = 1'b0;
               next_s.conv  = CONV_IDLE;
            end
         end
      endcase

      // Latch results coming out of the FIFO
      if (fifoOutValid && fifoOutReady) begin
         next_s.result[fifoOutData[WORD_W-1 -: CH_W]] =
            fifoOutData[CODE_W-1:0];
         next_s.latched = next_s.latched + 1'b1;
      end

      // Readout frames, independent of trigger levels
      if (fall[IN_CSN]) begin
         next_s.inFrame   = 1'b1;
         next_s.rdIdx     = '0;
         next_s.bitCnt    = '0;
         next_s.firstData = mode == MODE_SER;
         for (int i = 0; i < HALF_CH; i++) begin
            next_s.shA[(HALF_CH-1-i)*CODE_W +: CODE_W] = s.result[i];
            next_s.shB[(HALF_CH-1-i)*CODE_W +: CODE_W] =
               s.result[i + HALF_CH];
         end
      end else if (rise[IN_CSN]) begin
         next_s.inFrame   = 1'b0;
         next_s.firstData = 1'b0;
      end else if (s.inFrame && mode == MODE_SER) begin
         if (rise[IN_RDCLK]) begin
            next_s.shA    = s.shA << 1;
            next_s.shB    = s.shB << 1;
            next_s.bitCnt = s.bitCnt + 1'b1;
            if (s.bitCnt == BIT_W'(CODE_W - 1)) begin
               next_s.firstData = 1'b0;
            end
         end
      end else if (s.inFrame && fall[IN_RDCLK]) begin
         next_s.rdIdx = s.rdIdx + 1'b1;
         if (mode == MODE_PAR) begin
            chIdx = s.rdIdx[CH_W-1:0];
            next_s.dataOut = sadc_sext(s.result[chIdx]);
         end else begin
            chIdx = s.rdIdx[RD_W-1:1];
            word  = sadc_sext(s.result[chIdx]);
            // Byte order follows the high-byte-first pin
            next_s.dataOut = (s.rdIdx[0] ^ s.lvl[IN_HBEN])
                             ? {8'h00, word[15:8]}
                             : {8'h00, word[7:0]};
         end
         next_s.firstData = chIdx == '0;
      end
   end

   // Asynchronous reset clears results and aborts any run
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s     <= '0;
         s.s1  <= SYNC_RST;
         s.s2  <= SYNC_RST;
         s.s3  <= SYNC_RST;
         s.lvl <= SYNC_RST;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   AST_REFERENCE: assert property (
      referencePinOe == referenceSelect && bandgapOn == referenceSelect
      && referenceBufferOn)
      else $error("reference enables do not follow select");

   AST_SPAN: assert property (
      rangeSelect |-> rangeWide && codeStepNv == STEP_WIDE_NV)
      else $error("wide span not selected");

   AST_POWER: assert property (
      !powerDownN |-> (shutdown ^ standby) && standby == rangeSelect)
      else $error("power-down flavour wrong");

   AST_BUSY_HOLD: assert property (
      $rose(busy) |-> holdA && holdB && s.conv == CONV_RUN)
      else $error("busy rose without both halves held");

   AST_BUSY_IGNORE: assert property (
      busy && (rise[IN_TRGA] || rise[IN_TRGB]) && s.conv == CONV_RUN
      |=> busy && s.convCh == $past(s.convCh))
      else $error("trigger disturbed a running conversion");

   AST_BUSY_END: assert property (
      $fell(busy) |-> resultValid && s.latched == LATCH_ALL
      && !fifoOutValid)
      else $error("busy ended before all results latched");

   AST_BUS_DRIVE: assert property (
      dataOe |-> !s.lvl[IN_CSN] && !s.lvl[IN_RDCLK] && mode != MODE_SER)
      else $error("bus driven without both strobes low");

   AST_CS_RELEASE: assert property (
      rise[IN_CSN] |=> !dataOe && !serialOe && !firstData)
      else $error("outputs still on after chip select rise");

   AST_SIGN: assert property (
      dataOe && mode == MODE_PAR
      |-> dataOut[BUS_W-1 -: 2] == {2{dataOut[CODE_W-1]}})
      else $error("parallel word not sign extended");

   AST_SER_FIRST: assert property (
      fall[IN_CSN] && mode == MODE_SER
      |=> firstData && serialOe
      && serialOutA == $past(s.result[0][CODE_W-1]))
      else $error("serial frame did not start with channel 1");

   AST_SER_SHIFT: assert property (
      serialOe && rise[IN_RDCLK] && !rise[IN_CSN]
      && s.bitCnt == BIT_W'(CODE_W - 1) |=> !firstData)
      else $error("first-data flag held past 14 shifts");

   COV_TIED: cover property (rise[IN_TRGA] && rise[IN_TRGB] && !busy);
   COV_SPLIT: cover property (s.armA && !s.armB ##[1:200] busy);
   COV_PAR: cover property (dataOe && firstData && mode == MODE_PAR);
   COV_SER: cover property (serialOe && s.bitCnt == BIT_W'(CODE_W));
   COV_FULL: cover property (s.conv == CONV_PUSH && !fifoInReady);

endmodule

/* File: src/sadc_pkg.sv */
// Purpose: Shared constants and types of the sampling converter control.
// Assumes: 10 MHz ref_clk; eight channels of 14-bit codes.
// Notes:   Times are in ns; cycle counts derive from them.
package sadc_pkg;

   // ------------------------------------------------------------
   // Code format
   // ------------------------------------------------------------
   localparam int NUM_CH     = 8;
   localparam int HALF_CH    = 4;
   localparam int CH_W       = 3;
   localparam int CODE_W     = 14;
   localparam int BUS_W      = 16;
   localparam int WORD_W     = CH_W + CODE_W;
   localparam int RD_W       = 4;
   localparam int BIT_W      = 6;
   localparam int CODE_STEPS = 16384;
   localparam logic [CH_W:0] LATCH_ALL = 4'h8;

   // Code step in nV: full-scale range over the code count
   localparam longint FSR_WIDE_UV   = 20000000;
   localparam longint FSR_NARROW_UV = 10000000;
   localparam int     STEP_W        = 21;
   localparam logic [STEP_W-1:0] STEP_WIDE_NV =
      STEP_W'(FSR_WIDE_UV * 1000 / CODE_STEPS);
   localparam logic [STEP_W-1:0] STEP_NARROW_NV =
      STEP_W'(FSR_NARROW_UV * 1000 / CODE_STEPS);

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int CONV_TIME_NS  = 400;
   localparam int CONV_CYCLES   =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = $clog2(CONV_CYCLES + 1);
   localparam int FIFO_DEPTH    = 4;

   // ------------------------------------------------------------
   // Synchronised pin inputs
   // ------------------------------------------------------------
   localparam int NSYNC    = 8;
   localparam int IN_TRGA  = 0;
   localparam int IN_TRGB  = 1;
   localparam int IN_RDCLK = 2;
   localparam int IN_CSN   = 3;
   localparam int IN_PDN   = 4;
   localparam int IN_IFSEL = 5;
   localparam int IN_BSEL  = 6;
   localparam int IN_HBEN  = 7;
   // Strobe, chip select and power pins rest high
   localparam logic [NSYNC-1:0] SYNC_RST = 8'h1C;

   typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_PUSH, CONV_WAIT}
      sadc_conv_t;
   typedef enum logic [1:0] {MODE_PAR, MODE_SER, MODE_BYTE} sadc_mode_t;

   function automatic sadc_mode_t sadc_mode(input logic ifSel,
                                            input logic byteSel);
      if (!ifSel)
         return MODE_PAR;
      return byteSel ? MODE_BYTE : MODE_SER;
   endfunction

   function automatic logic [BUS_W-1:0] sadc_sext(
         input logic [CODE_W-1:0] code);
      return {{(BUS_W - CODE_W){code[CODE_W-1]}}, code};
   endfunction

endpackage

/* File: src/sadc_fifo.sv */
// Purpose: Small result FIFO between converter and result registers.
// Assumes: DEPTH is a power of two.
// Notes:   Read data is a mux of stored words, valid with outValid.
`timescale 1ns/1ns
module sadc_fifo
   #(parameter int WIDTH = 8,
     parameter int DEPTH = 4)
   (input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0]                 wr;
      logic [PW:0]                 rd;
   } sadc_fifo_t;

   sadc_fifo_t s;
   sadc_fifo_t next_s;

   // ------------------------------------------------------------
   // Pointers carry one extra bit to tell full from empty
   // ------------------------------------------------------------
   assign inReady  = (s.wr ^ s.rd) != {1'b1, {PW{1'b0}}};
   assign outValid = s.wr != s.rd;
   assign outData  = s.mem[s.rd[PW-1:0]];

   always_comb begin
      next_s = s;
      if (inValid && inReady) begin
         next_s.mem[s.wr[PW-1:0]] = inData;
         next_s.wr = s.wr + 1'b1;
      end
      if (outValid && outReady) begin
         next_s.rd = s.rd + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule

/* File: verification/sadc_far_model.sv */
// Purpose: Analog core and serial shift-clock source facing the control.
// Assumes: Codes depend only on the channel being converted.
// Notes:   The shift clock idles high, starts toggling when run rises and ends high after run falls.
`timescale 1ns/1ns
module sadc_far_model
   import sadc_pkg::*;
   (input  wire logic              run,
    input  wire logic [CH_W-1:0]   adcChannel,
    output logic      [CODE_W-1:0] adcCode,
    output logic                   shiftClk);
   // Channels 5-8 give negative codes so sign extension is exercised
   assign adcCode = {adcChannel, 11'h2A5};
   initial shiftClk = 1'b1;
   // Rising edge ends each bit; clock stands still between frames
   always begin
      if (run) begin
         #400 shiftClk = 1'b0;
         #400 shiftClk = 1'b1;
      end else
         @(posedge run);
   end
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench of the converter control block.
// Assumes: Inputs change at the falling edge of ref_clk; the serial shift clock and run change 7 ns after it.
// Notes:   Pin syncs delay every clocked response by three to four cycles.
`timescale 1ns/1ns
module tb;
   import sadc_pkg::*;
   logic                ref_clk, reset, trA, trB, reference_select, rngSel, pdn;
   logic                ifSel, bSel, hbf, rd, csN, run, shiftClk, rdClk;
   logic                holdA, holdB, busy, resultValid, firstData, dataOe;
   logic                serialOutA, serialOutB, serialOe, referencePinOe;
   logic                bandgapOn, referenceBufferOn, rangeWide;
   logic                shutdown, standby;
   logic [CH_W-1:0]     adcChannel;
   logic [CODE_W-1:0]   adcCode;
   logic [BUS_W-1:0]    dataOut, e, eB;
   logic [STEP_W-1:0]   codeStepNv;
   int                  num_errors, samples_checked;

   assign rdClk = (ifSel && !bSel) ? shiftClk : rd;
   sadc_control sadc_control_inst (.ref_clk, .reset, .triggerA(trA),
      .triggerB(trB), .referenceSelect(reference_select), .rangeSelect(rngSel),
      .powerDownN(pdn), .interfaceSelect(ifSel), .byteSerialSelect(bSel),
      .highByteFirst(hbf), .readStrobeClk(rdClk), .chipSelectN(csN),
      .adcCode, .adcChannel, .holdA, .holdB, .busy, .resultValid,
      .firstData, .dataOut, .dataOe, .serialOutA, .serialOutB, .serialOe,
      .referencePinOe, .bandgapOn, .referenceBufferOn, .rangeWide,
      .codeStepNv, .shutdown, .standby);
   sadc_far_model sadc_far_model_inst (.run, .adcChannel, .adcCode,
      .shiftClk);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   function automatic logic [15:0] sx(input logic [2:0] ch);
      return {{2{ch[2]}}, ch, 11'h2A5};
   endfunction
   task automatic chk(input logic g, input logic x);
      samples_checked++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: flag %b not %b", $time, g, x);
      end
   endtask
   task automatic chkv(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: value %h not %h", $time, g, x);
      end
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   // Bounded wait, so a stuck busy shows as a mismatch, not a hang
   task automatic wait_busy(input logic lvl, input int lim);
      for (int n = 0; n < lim && busy !== lvl; n++)
         @(negedge ref_clk);
      chk(busy, lvl);
   endtask
   task automatic conv(input bit lone);
      trA = 1'b1;
      if (lone) begin
         repeat (6) @(negedge ref_clk);
         chk(holdA, 1'b1);
         chk(holdB, 1'b0);
         chk(busy, 1'b0);
      end
      trB = 1'b1;
      wait_busy(1'b1, 10);
      chk(resultValid, 1'b0);
      wait_busy(1'b0, 200);
      chk(resultValid, 1'b1);
   endtask
   task automatic strobe(input logic [15:0] d, input logic f);
      rd = 1'b0;
      repeat (5) @(negedge ref_clk);
      chkv(32'(dataOut), 32'(d));
      chk(firstData, f);
      chk(dataOe, 1'b1);
      rd = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk(dataOe, 1'b0);
   endtask
   task automatic frame(input logic lvl);
      csN = lvl;
      repeat (5) @(negedge ref_clk);
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #1_000_000;
      num_errors++;
      give_verdict();
   end
   initial begin
      {reset, rd, csN, pdn} = 4'hF;
      {trA, trB, reference_select, rngSel, ifSel, bSel, hbf, run} = 8'h00;
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      for (int i = 0; i < 4; i++) begin
         {reference_select, rngSel} = 2'(i);
         @(negedge ref_clk);
         chk(bandgapOn, reference_select);
         chk(referencePinOe, reference_select);
         chk(referenceBufferOn, 1'b1);
         chk(rangeWide, rngSel);
         chkv(32'(codeStepNv), rngSel ? 32'h12A05F : 32'h9502F);
         pdn = 1'b0;
         @(negedge ref_clk);
         chk(shutdown, !rngSel);
         chk(standby, rngSel);
      end
      // Span settling time after the last span change
      repeat (800) @(negedge ref_clk);
      {trA, trB} = 2'h3;
      repeat (8) @(negedge ref_clk);
      chk(busy, 1'b0);
      {trA, trB, pdn} = 3'h1;
      repeat (8) @(negedge ref_clk);
      conv(1'b1);
      // Triggers stay high through the read on purpose
      frame(1'b0);
      for (int c = 0; c < 8; c++)
         strobe(sx(3'(c)), c == 0);
      frame(1'b1);
      {trA, trB, ifSel, bSel, hbf} = 5'h07;
      e = sx(3'h0);
      frame(1'b0);
      strobe({8'h00, e[15:8]}, 1'b1);
      strobe({8'h00, e[7:0]}, 1'b1);
      e = sx(3'h1);
      strobe({8'h00, e[15:8]}, 1'b0);
      // Mode pin settles while chip select is high, before the frame
      bSel = 1'b0;
      frame(1'b1);
      frame(1'b0);
      chk(serialOe, 1'b1);
      chk(firstData, 1'b1);
      e  = sx(3'h0);
      eB = sx(3'h4);
      #7 run = 1'b1;
      for (int i = 13; i >= 0; i--) begin
         @(negedge shiftClk);
         chk(serialOutA, e[i]);
         chk(serialOutB, eB[i]);
      end
      run = 1'b0;
      repeat (10) @(negedge ref_clk);
      chk(firstData, 1'b0);
      frame(1'b1);
      chk(serialOe, 1'b0);
      {ifSel, trA, trB} = 3'h3;
      wait_busy(1'b1, 10);
      chk(resultValid, 1'b0);
      repeat (10) @(negedge ref_clk);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(busy, 1'b0);
      reset = 1'b0;
      chk(resultValid, 1'b0);
      chkv(32'(dataOut), 32'h0);
      {trA, trB} = 2'h0;
      repeat (8) @(negedge ref_clk);
      frame(1'b0);
      strobe(16'h0000, 1'b1);
      frame(1'b1);
      conv(1'b0);
      give_verdict();
   end
endmodule
